// ### gpia_pkg.sv
// Package: register map, reset values and bus encodings for the GPIO port.
// Assumes one AHB-Lite slave select per port and 32-bit aligned registers.
package gpia_pkg;
   localparam int LINES = 8;
   localparam logic [11:0] OFS_DATA = 12'h3fc;
   localparam logic [11:0] OFS_DIR = 12'h400;
   localparam logic [11:0] OFS_MASK = 12'h410;
   localparam logic [11:0] OFS_RAW = 12'h414;
   localparam logic [11:0] OFS_MASKED = 12'h418;
   localparam logic [11:0] OFS_ICR = 12'h41c;
   localparam logic [11:0] OFS_AFSEL = 12'h420;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] AFSEL_RST_PORT_B = 8'h80;
   localparam logic [7:0] AFSEL_RST_PORT_C = 8'h0f;
   localparam int TRIG_BIT_PORT_B = 4;
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;
   typedef enum logic [1:0] {BUS_IDLE, BUS_ACCESS, BUS_RESP} gpia_bus_state_type;
endpackage : gpia_pkg

// ### gpia_irq_if.sv
// Interface: carries pin levels, mask and clear into the edge-detect core
// and its raw and masked status back to the register block.
`timescale 1ns/10ps
interface gpia_irq_if #(parameter int WIDTH = 8);
   logic [WIDTH-1:0] pin_in;
   logic [WIDTH-1:0] mask;
   logic [WIDTH-1:0] clear;
   logic [WIDTH-1:0] raw;
   logic [WIDTH-1:0] masked;
   logic [WIDTH-1:0] set_evt;
   modport core (input pin_in, input mask, input clear, output raw, output masked,
      output set_evt);
   modport ctrl (output pin_in, output mask, output clear, input raw, input masked,
      input set_evt);
endinterface : gpia_irq_if

// ### gpia_irq_core.sv
// Edge-detect interrupt core: rising edges set raw status, clear bits drop it.
// Assumes pin levels are already synchronous to clk_sys.
`timescale 1ns/10ps
module gpia_irq_core #(
   parameter int WIDTH = 8
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   gpia_irq_if.core irq
);
   logic [WIDTH-1:0] prev_reg;
   logic [WIDTH-1:0] prev_next;
   logic [WIDTH-1:0] raw_reg;
   logic [WIDTH-1:0] raw_next;
   logic [WIDTH-1:0] edge_seen;

   // ----------------------------------------
   // Edge detection
   // ----------------------------------------
   always_comb begin
      edge_seen = irq.pin_in & ~prev_reg;
      prev_next = irq.pin_in;
      // Set beats clear so an edge in the clearing cycle survives
      raw_next = (raw_reg & ~irq.clear) | edge_seen;
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         prev_reg <= '0;
         raw_reg <= '0;
      end else begin
         prev_reg <= prev_next;
         raw_reg <= raw_next;
      end
   end

   assign irq.raw = raw_reg;
   assign irq.masked = raw_reg & irq.mask;
   assign irq.set_evt = edge_seen;
endmodule : gpia_irq_core

// ### gpia_port.sv
// GPIO port top: AHB-Lite register slave, pin muxing and interrupt status.
// Assumes pins and alternate-function signals are synchronous to clk_sys;
// reset_n is driven by both power-on reset and the external reset pin.
//
// Overview of operation
// - Masked status is raw AND mask, resets zero
// - Port B bit 4 unmasked edge triggers converter
// - Converter starts only with external source selected
// - Write one clears latched edge, zero ignored
// - Function select one gives line to hardware
// - Reset: inputs, select zero except debug lines
// - Power-on and pin reset restore defaults
// - Raw status sets on detected edge, unmasked
`timescale 1ns/10ps
module gpia_port #(
   parameter logic [7:0] AFSEL_RESET = gpia_pkg::AFSEL_RST_PORT_B,
   parameter bit HAS_CONV_TRIG = 1'b1,
   parameter int TRIG_BIT = gpia_pkg::TRIG_BIT_PORT_B
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe_n,
   input wire logic [7:0] alt_out,
   input wire logic [7:0] alt_oe,
   output logic [7:0] alt_in,
   output logic port_irq,
   input wire logic conv_event_ext_sel,
   output logic conv_trig,
   output logic conv_start
);
   localparam int W = gpia_pkg::LINES;

   gpia_pkg::gpia_bus_state_type state_reg, state_next;
   logic [11:0] addr_reg, addr_next;
   logic write_reg, write_next;
   logic [31:0] hrdata_reg, hrdata_next;
   logic [W-1:0] data_reg, data_next;
   logic [W-1:0] dir_reg, dir_next;
   logic [W-1:0] mask_reg, mask_next;
   logic [W-1:0] afsel_reg, afsel_next;
   logic [W-1:0] clear_pulse;
   logic trig_reg, trig_next;
   logic irq_reg, irq_next;
   logic addr_valid;

   gpia_irq_if #(.WIDTH(W)) irq_bus ();

   gpia_irq_core #(.WIDTH(W)) u_core (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .irq(irq_bus.core)
   );

   function automatic logic [31:0] zext(input logic [W-1:0] v);
      zext = {{(32 - W){1'b0}}, v};
   endfunction : zext

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   // One wait state per transfer so a read always sees a completed write
   assign addr_valid = hsel && hready && (htrans == gpia_pkg::HTRANS_NONSEQ);

   always_comb begin
      state_next = state_reg;
      addr_next = addr_reg;
      write_next = write_reg;
      hrdata_next = hrdata_reg;
      data_next = data_reg;
      dir_next = dir_reg;
      mask_next = mask_reg;
      afsel_next = afsel_reg;
      clear_pulse = '0;
      unique case (state_reg)
         gpia_pkg::BUS_IDLE, gpia_pkg::BUS_RESP: begin
            if (addr_valid) begin
               addr_next = haddr[11:0];
               write_next = hwrite;
               state_next = gpia_pkg::BUS_ACCESS;
            end else begin
               state_next = gpia_pkg::BUS_IDLE;
            end
         end
         gpia_pkg::BUS_ACCESS: begin
            state_next = gpia_pkg::BUS_RESP;
            hrdata_next = '0;
            if (write_reg) begin
               unique case (addr_reg)
                  gpia_pkg::OFS_DATA: data_next = hwdata[W-1:0];
                  gpia_pkg::OFS_DIR: dir_next = hwdata[W-1:0];
                  gpia_pkg::OFS_MASK: mask_next = hwdata[W-1:0];
                  gpia_pkg::OFS_ICR: clear_pulse = hwdata[W-1:0];
                  gpia_pkg::OFS_AFSEL: afsel_next = hwdata[W-1:0];
                  default: ;
               endcase
            end else begin
               unique case (addr_reg)
                  gpia_pkg::OFS_DATA: hrdata_next = zext(data_reg);
                  gpia_pkg::OFS_DIR: hrdata_next = zext(dir_reg);
                  gpia_pkg::OFS_MASK: hrdata_next = zext(mask_reg);
                  gpia_pkg::OFS_RAW: hrdata_next = zext(irq_bus.raw);
                  gpia_pkg::OFS_MASKED: hrdata_next = zext(irq_bus.masked);
                  gpia_pkg::OFS_AFSEL: hrdata_next = zext(afsel_reg);
                  default: hrdata_next = '0;
               endcase
            end
         end
         default: state_next = gpia_pkg::BUS_IDLE;
      endcase
   end

   // ----------------------------------------
   // Interrupt and converter trigger
   // ----------------------------------------
   always_comb begin
      irq_next = |irq_bus.masked;
      trig_next = HAS_CONV_TRIG && irq_bus.set_evt[TRIG_BIT] && mask_reg[TRIG_BIT];
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         // Every reset source lands here, debug lines back in debug mode
         state_reg <= gpia_pkg::BUS_IDLE;
         addr_reg <= '0;
         write_reg <= 1'b0;
         hrdata_reg <= '0;
         data_reg <= gpia_pkg::RST_ZERO;
         dir_reg <= gpia_pkg::RST_ZERO;
         mask_reg <= gpia_pkg::RST_ZERO;
         afsel_reg <= AFSEL_RESET;
         trig_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         addr_reg <= addr_next;
         write_reg <= write_next;
         hrdata_reg <= hrdata_next;
         data_reg <= data_next;
         dir_reg <= dir_next;
         mask_reg <= mask_next;
         afsel_reg <= afsel_next;
         trig_reg <= trig_next;
         irq_reg <= irq_next;
      end
   end

   assign irq_bus.pin_in = pin_in;
   assign irq_bus.mask = mask_reg;
   assign irq_bus.clear = clear_pulse;

   // ----------------------------------------
   // Pin muxing
   // ----------------------------------------
   always_comb begin
      for (int i = 0; i < W; i++) begin
         pin_out[i] = afsel_reg[i] ? alt_out[i] : data_reg[i];
         pin_oe_n[i] = afsel_reg[i] ? ~alt_oe[i] : ~dir_reg[i];
      end
   end

   assign alt_in = pin_in;
   assign hrdata = hrdata_reg;
   assign hreadyout = (state_reg != gpia_pkg::BUS_ACCESS);
   assign hresp = gpia_pkg::HRESP_OKAY;
   assign port_irq = irq_reg;
   assign conv_trig = trig_reg;
   // Converter ignores the trigger unless its external source is chosen
   assign conv_start = trig_reg & conv_event_ext_sel;
endmodule : gpia_port

// ### gpia_port_chk.sv
// Checker: bus wait state, trigger pulse and reset state of the port.
// Assumes one slave, hready taken from hreadyout.
`timescale 1ns/10ps
module gpia_port_chk (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic [7:0] pin_in,
   input wire logic [7:0] pin_oe_n,
   input wire logic [7:0] alt_oe,
   input wire logic [7:0] alt_in,
   input wire logic port_irq,
   input wire logic conv_event_ext_sel,
   input wire logic conv_trig,
   input wire logic conv_start
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   sequence one_wait_s;
      !hreadyout ##1 hreadyout;
   endsequence
   one_wait_a: assert property (hsel && hready && htrans == 2'h2 |=> one_wait_s)
      else $error("wait state wrong");
   upper_zero_a: assert property (hrdata[31:8] == 24'h0) else $error("upper bits set");
   trig_pulse_a: assert property (conv_trig |=> !conv_trig) else $error("long trigger");
   trig_cause_a: assert property (conv_trig |->
      $past(pin_in[4]) && !$past(pin_in[4], 2)) else $error("trigger without edge");
   conv_gate_a: assert property (conv_start == (conv_trig && conv_event_ext_sel))
      else $error("start gate wrong");
   alt_pass_a: assert property (alt_in == pin_in) else $error("alt input wrong");
   rst_state_a: assert property ($rose(reset_n) |->
      !port_irq && pin_oe_n == {~alt_oe[7], 7'h7f}) else $error("bad reset state");
   // No re-rise allowed, so the low level is checked on the edge after the fall
   irq_quiet_a: assert property ($fell(port_irq) |=> !port_irq) else $error("irq chatter");
endmodule : gpia_port_chk
bind gpia_port gpia_port_chk u_gpia_port_chk (.clk_sys(clk_sys), .reset_n(reset_n),
   .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
   .pin_in(pin_in), .pin_oe_n(pin_oe_n), .alt_oe(alt_oe), .alt_in(alt_in),
   .port_irq(port_irq), .conv_event_ext_sel(conv_event_ext_sel), .conv_trig(conv_trig),
   .conv_start(conv_start));

// ### gpia_far_model.sv
// Partner: pin levels and a converter counting starts.
// Assumes released lines follow the level the bench sets.
`timescale 1ns/10ps
module gpia_far_model (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe_n,
   input wire logic [7:0] ext_level,
   input wire logic conv_start,
   output logic [7:0] pin_in,
   output int conv_count
);
   assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         conv_count <= 0;
      end else if (conv_start) begin
         conv_count <= conv_count + 1;
      end
   end
endmodule : gpia_far_model

// ### gpio_irq_status_altfunc_test.sv
// Testbench: register rows, edge interrupts, converter trigger, resets.
// Assumes the partner model drives the pins.
`timescale 1ns/10ps
module gpio_irq_status_altfunc_test;
   typedef struct {logic [11:0] a; logic w; logic [31:0] d;} gpia_row_type;
   logic clk_sys, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, ext_sel = 1'b1;
   logic hreadyout, hresp, port_irq, conv_trig, conv_start;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [7:0] pin_in, pin_out, pin_oe_n, ext = 8'h00;
   int fail_count = 0, n_checks = 0, conv_count;
   gpia_row_type rows [10] = '{'{gpia_pkg::OFS_DIR, 1, 32'h60}, '{gpia_pkg::OFS_DIR, 0, 32'h60},
      '{gpia_pkg::OFS_AFSEL, 1, 32'h0f}, '{gpia_pkg::OFS_AFSEL, 0, 32'h0f},
      '{gpia_pkg::OFS_DATA, 1, 32'h80}, '{gpia_pkg::OFS_DATA, 0, 32'h80},
      '{12'h800, 1, 32'hff}, '{12'h800, 0, 32'h0}, '{gpia_pkg::OFS_ICR, 0, 32'h0},
      '{gpia_pkg::OFS_MASKED, 0, 32'h0}};
   gpia_port u_gpia_port (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe_n(pin_oe_n), .alt_out(8'ha5), .alt_oe(8'h05), .alt_in(),
      .port_irq(port_irq), .conv_event_ext_sel(ext_sel), .conv_trig(conv_trig),
      .conv_start(conv_start));
   gpia_far_model u_gpia_far_model (.clk_sys(clk_sys), .reset_n(reset_n), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .ext_level(ext), .conv_start(conv_start), .pin_in(pin_in),
      .conv_count(conv_count));
   task automatic results();
      $display("checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   // Ready is looked at on the falling edge, so it never races the launch edge
   task automatic waitr();
      int n;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         fail_count++;
         $display("unexpected at %0t: ready timeout", $time);
         results();
      end
      rd = hrdata;
      @(posedge clk_sys);
   endtask : waitr
   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= gpia_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      waitr();
      hsel <= 1'b0;
      htrans <= gpia_pkg::HTRANS_IDLE;
      hwdata <= d;
      waitr();
      chk({31'h0, hresp}, 32'h0);
   endtask : bus
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask : settle
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      reset_n <= 1'b1;
      bus(gpia_pkg::OFS_AFSEL, 0, 32'h0);
      chk(rd, 32'h80);
      foreach (rows[i]) begin
         bus(rows[i].a, rows[i].w, rows[i].d);
         if (!rows[i].w) chk(rd, rows[i].d);
      end
      settle(1);
      chk({16'h0, pin_oe_n, pin_out}, 32'h9a85);
      bus(gpia_pkg::OFS_MASK, 1, 32'h10);
      @(posedge clk_sys);
      ext <= 8'h10;
      // Trigger is registered from the edge itself, the interrupt a cycle later
      settle(1);
      chk({30'h0, port_irq, conv_trig}, 32'h1);
      settle(0);
      chk({30'h0, port_irq, conv_trig}, 32'h2);
      bus(gpia_pkg::OFS_ICR, 1, 32'h01);
      bus(gpia_pkg::OFS_RAW, 0, 32'h0);
      chk(rd, 32'h14);
      bus(gpia_pkg::OFS_MASKED, 0, 32'h0);
      chk(rd, 32'h10);
      bus(gpia_pkg::OFS_ICR, 1, 32'h10);
      ext <= 8'h00;
      ext_sel <= 1'b0;
      settle(2);
      chk({31'h0, port_irq}, 32'h0);
      @(posedge clk_sys);
      ext <= 8'h10;
      settle(3);
      chk(32'(conv_count), 32'h1);
      bus(gpia_pkg::OFS_AFSEL, 1, 32'h80);
      bus(gpia_pkg::OFS_AFSEL, 1, 32'h01);
      ext <= 8'h00;
      reset_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      reset_n <= 1'b1;
      bus(gpia_pkg::OFS_DIR, 0, 32'h0);
      chk(rd, 32'h0);
      bus(gpia_pkg::OFS_AFSEL, 0, 32'h0);
      chk(rd, 32'h80);
      results();
   end
endmodule : gpio_irq_status_altfunc_test
